// [verilog/radio_modem_frame_control.sv]
// Operation
// - registers mapped from 0xdf02 in data space
// - coordinator accepts frames without destination address
// - bit 3 enables address recognition, reset on
// - hysteresis 0..7 dB, resets to 2
// - rule 00 reserved, 01 uses threshold minus hysteresis
// - signed threshold 0xe0, clear below it
// - auto checksum appended on transmit, checked on receive
// - acknowledge accepted, requested, crc-valid frames
// - preamble 2 to 32 zero bytes, steps 2
// - sync lsb nibble first, F nibbles special
// - normal acknowledgement exactly 12 symbols after frame
// - slotted acknowledgement 12..31 symbols, 20-symbol aligned
// - level select on means extended correlator filtering
// - correlator threshold gates sync search, reset 0x10
`timescale 1ns/1ps
`default_nettype none

module tx_byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    // full and empty come straight from the occupancy count
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module radio_modem_frame_control (
    input  wire logic         SYS_CLK_I,
    input  wire logic         RST_B_I,
    input  wire logic [15:0]  XADDR_I,
    input  wire logic [7:0]   XWDATA_I,
    input  wire logic         XWR_I,
    input  wire logic         XRD_I,
    output logic [7:0]        XRDATA_O,
    input  wire logic [15:0]  SYNC_PATTERN_I,
    input  wire logic [7:0]   RSSI_I,
    input  wire logic         RSSI_VALID_I,
    output logic              CHANNEL_CLEAR_O,
    input  wire logic [7:0]   TX_DATA_I,
    input  wire logic         TX_LAST_I,
    input  wire logic         TX_VALID_I,
    output logic              TX_READY_O,
    output logic [7:0]        TX_BYTE_O,
    output logic              TX_BYTE_VALID_O,
    input  wire logic         TX_BYTE_READY_I,
    input  wire logic [3:0]   RX_NIBBLE_I,
    input  wire logic         RX_NIBBLE_VALID_I,
    input  wire logic [4:0]   CORR_LEVEL_I,
    output logic              RX_SYNC_FOUND_O,
    input  wire logic [7:0]   RX_BYTE_I,
    input  wire logic         RX_BYTE_VALID_I,
    input  wire logic         RX_FRAME_END_I,
    input  wire logic         RX_NO_DEST_I,
    input  wire logic         RX_ADDR_MATCH_I,
    input  wire logic         RX_ACK_REQ_I,
    output logic              FRAME_ACCEPT_O,
    output logic              RX_CRC_OK_O,
    output logic              RX_DONE_O,
    output logic              ACK_START_O
);
    import radio_modem_pkg::*;

    // one byte, lsb first, through the reflected crc register
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
        end
        return r;
    endfunction

    // F nibbles go out as zero symbols
    function automatic logic [3:0] tx_nib(input logic [3:0] n);
        return (n == 4'hf) ? 4'h0 : n;
    endfunction

    // pad to the next 20-symbol boundary, never under 12 symbols
    function automatic logic [4:0] slot_delay(input logic [4:0] phase);
        logic [4:0] d;
        d = SLOT_SYMBOLS - phase;
        return (d < ACK_SYMBOLS) ? d + SLOT_SYMBOLS : d;
    endfunction

    logic [7:0] filter_ctrl;
    logic [7:0] frame_ctrl;
    logic [7:0] ack_corr_ctrl;
    logic [7:0] clear_thr;

    // field views
    wire       coordinator_role          = filter_ctrl[COORD_BIT];
    wire       addr_decode_enable        = filter_ctrl[ADDR_DEC_BIT];
    wire [2:0] channel_clear_hysteresis  = filter_ctrl[HYST_MSB:0];
    wire [1:0] channel_clear_rule_select = frame_ctrl[RULE_MSB:RULE_LSB];
    wire       auto_checksum_enable      = frame_ctrl[CRC_EN_BIT];
    wire       auto_acknowledge_enable   = frame_ctrl[ACK_EN_BIT];
    wire [3:0] preamble_code             = frame_ctrl[PRE_MSB:0];
    wire       slotted_ack               = ack_corr_ctrl[SLOT_BIT];
    wire       correlator_level_select   = ack_corr_ctrl[LEVEL_BIT];
    wire [4:0] correlator_threshold      = ack_corr_ctrl[CORR_MSB:0];

    // address decode of the register port
    wire sel_filter = (XADDR_I == FILTER_CTRL_ADDR);
    wire sel_frame  = (XADDR_I == FRAME_CTRL_ADDR);
    wire sel_ack    = (XADDR_I == ACK_CORR_CTRL_ADDR);
    wire sel_thr    = (XADDR_I == CLEAR_THR_ADDR);
    wire [7:0] rd_mux = sel_filter ? filter_ctrl : sel_frame ? frame_ctrl :
                        sel_ack ? ack_corr_ctrl : sel_thr ? clear_thr : 8'h00;

    // register writes; unmapped addresses are ignored
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            filter_ctrl   <= FILTER_CTRL_RST;
            frame_ctrl    <= FRAME_CTRL_RST;
            ack_corr_ctrl <= ACK_CORR_CTRL_RST;
            clear_thr     <= CLEAR_THR_RST;
        end else if (XWR_I) begin
            // reserved filter_ctrl bits are dropped, so a stray one does no harm
            if (sel_filter) filter_ctrl <= XWDATA_I & FILTER_CTRL_WMASK;
            if (sel_frame) frame_ctrl <= XWDATA_I;
            if (sel_ack) ack_corr_ctrl <= XWDATA_I;
            if (sel_thr) clear_thr <= XWDATA_I;
        end
    end

    // read data registered, zero for unmapped addresses
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) XRDATA_O <= 8'h00;
        else if (XRD_I) XRDATA_O <= rd_mux;
    end

    // clear-channel compare in signed 9 bits to avoid wrap
    wire signed [8:0] rssi_s   = {RSSI_I[7], RSSI_I};
    wire signed [8:0] thr_s    = {clear_thr[7], clear_thr};
    wire signed [8:0] thr_hyst = thr_s - $signed({6'h00, channel_clear_hysteresis});
    wire below_thr  = (rssi_s < thr_s);
    wire below_hyst = (rssi_s < thr_hyst);
    wire clear_next = (channel_clear_rule_select == RULE_RESERVED) ? 1'b0 :
                      (channel_clear_rule_select == RULE_HYST) ? below_hyst : below_thr;

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) CHANNEL_CLEAR_O <= 1'b0;
        else if (RSSI_VALID_I) CHANNEL_CLEAR_O <= clear_next;
    end

    // transmit path: buffer, then preamble, sync, data and crc
    logic [8:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_ready;
    tx_state_e  tx_state;
    logic [4:0] tx_cnt;
    logic [15:0] tx_crc;

    tx_byte_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i       (SYS_CLK_I),
        .rst_b_i     (RST_B_I),
        .in_data_i   ({TX_LAST_I, TX_DATA_I}),
        .in_valid_i  (TX_VALID_I),
        .in_ready_o  (TX_READY_O),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_ready)
    );

    wire [4:0] pre_last = {preamble_code, 1'b1}; // code n sends 2n+2 bytes
    wire [7:0] sync_lo  = {tx_nib(SYNC_PATTERN_I[7:4]), tx_nib(SYNC_PATTERN_I[3:0])};
    wire [7:0] sync_hi  = {tx_nib(SYNC_PATTERN_I[15:12]), tx_nib(SYNC_PATTERN_I[11:8])};
    wire out_free  = !TX_BYTE_VALID_O | TX_BYTE_READY_I;
    wire in_data   = (tx_state == TX_DATA);
    wire gen_valid = (tx_state == TX_PRE) | (tx_state == TX_SYNC) |
                     (tx_state == TX_CRC) | (in_data & fifo_valid);
    wire take      = gen_valid & out_free;
    wire last_cnt  = (tx_cnt == 5'd1);
    wire [7:0] gen_byte = (tx_state == TX_SYNC) ? (last_cnt ? sync_hi : sync_lo) :
                          (tx_state == TX_CRC) ? (last_cnt ? tx_crc[15:8] : tx_crc[7:0]) :
                          in_data ? fifo_data[7:0] : 8'h00;
    // the output stage stalls the buffer, so back-pressure reaches TX_READY_O
    assign fifo_ready = in_data & out_free;

    // output byte stage
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            TX_BYTE_VALID_O <= 1'b0;
            TX_BYTE_O       <= 8'h00;
        end else if (out_free) begin
            TX_BYTE_VALID_O <= gen_valid;
            TX_BYTE_O       <= gen_byte;
        end
    end

    // framing sequencer; a frame starts once its first byte is buffered
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            tx_state <= TX_IDLE;
            tx_cnt   <= 5'd0;
            tx_crc   <= CRC_INIT;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_cnt <= 5'd0;
                    tx_crc <= CRC_INIT;
                    if (fifo_valid) tx_state <= TX_PRE;
                end
                TX_PRE: if (take) begin
                    tx_cnt <= (tx_cnt == pre_last) ? 5'd0 : tx_cnt + 5'd1;
                    if (tx_cnt == pre_last) tx_state <= TX_SYNC;
                end
                TX_SYNC: if (take) begin
                    tx_cnt <= last_cnt ? 5'd0 : 5'd1;
                    if (last_cnt) tx_state <= TX_DATA;
                end
                TX_DATA: if (take) begin
                    tx_crc <= crc_byte(tx_crc, fifo_data[7:0]);
                    if (fifo_data[8]) begin
                        tx_state <= auto_checksum_enable ? TX_CRC : TX_IDLE;
                    end
                end
                TX_CRC: if (take) begin
                    tx_cnt <= 5'd1;
                    if (last_cnt) tx_state <= TX_IDLE;
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // receive sync search, gated by correlator level
    logic [1:0] sync_idx;
    logic       corr_prev;
    logic       rx_busy;
    logic [15:0] rx_crc;
    wire corr_hit = (CORR_LEVEL_I >= correlator_threshold);
    // extended filtering needs two good nibbles in a row
    wire corr_ok  = correlator_level_select ? (corr_hit & corr_prev) : corr_hit;
    wire [3:0] want_nib = SYNC_PATTERN_I[{sync_idx, 2'b00} +: 4];
    wire nib_match = (want_nib == 4'hf) | (want_nib == RX_NIBBLE_I);
    wire searching = RX_NIBBLE_VALID_I & !rx_busy & ((sync_idx != 2'd0) | corr_ok);
    wire sync_hit  = searching & nib_match & (sync_idx == 2'd3);

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            sync_idx        <= 2'd0;
            corr_prev       <= 1'b0;
            rx_busy         <= 1'b0;
            RX_SYNC_FOUND_O <= 1'b0;
        end else begin
            RX_SYNC_FOUND_O <= sync_hit;
            if (RX_NIBBLE_VALID_I) corr_prev <= corr_hit;
            if (searching) sync_idx <= nib_match ? sync_idx + 2'd1 : 2'd0;
            // a sync in the frame-end cycle must not be lost, so the set wins
            if (sync_hit) rx_busy <= 1'b1;
            else if (RX_FRAME_END_I) rx_busy <= 1'b0;
        end
    end

    // receive crc and frame verdict
    wire crc_good = auto_checksum_enable & (rx_crc == CRC_INIT);
    wire accept   = !addr_decode_enable | RX_ADDR_MATCH_I |
                    (coordinator_role & RX_NO_DEST_I);
    wire ack_arm  = RX_FRAME_END_I & auto_acknowledge_enable & accept &
                    RX_ACK_REQ_I & crc_good;

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            rx_crc         <= CRC_INIT;
            FRAME_ACCEPT_O <= 1'b0;
            RX_CRC_OK_O    <= 1'b0;
            RX_DONE_O      <= 1'b0;
        end else begin
            RX_DONE_O <= RX_FRAME_END_I;
            if (sync_hit) rx_crc <= CRC_INIT;
            else if (RX_BYTE_VALID_I) rx_crc <= crc_byte(rx_crc, RX_BYTE_I);
            if (RX_FRAME_END_I) begin
                FRAME_ACCEPT_O <= accept;
                RX_CRC_OK_O    <= crc_good;
            end
        end
    end

    // symbol timing; divider restarts at sync and at ack arm for exact delays
    logic [9:0] sym_div;
    logic [4:0] sfd_phase;
    logic [4:0] ack_wait;
    logic       ack_pending;
    wire sym_tick = (sym_div == 10'(SYMBOL_CYCLES - 1));

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            sym_div     <= 10'd0;
            sfd_phase   <= 5'd0;
            ack_wait    <= 5'd0;
            ack_pending <= 1'b0;
            ACK_START_O <= 1'b0;
        end else begin
            ACK_START_O <= ack_pending & sym_tick & (ack_wait == 5'd1);
            sym_div <= (sync_hit | ack_arm | sym_tick) ? 10'd0 : sym_div + 10'd1;
            if (sync_hit) sfd_phase <= 5'd0;
            else if (sym_tick) begin
                sfd_phase <= (sfd_phase == SLOT_SYMBOLS - 5'd1) ? 5'd0 : sfd_phase + 5'd1;
            end
            if (ack_arm) begin
                ack_pending <= 1'b1;
                ack_wait <= slotted_ack ? slot_delay(sfd_phase) : ACK_SYMBOLS;
            end else if (ack_pending & sym_tick) begin
                ack_wait <= ack_wait - 5'd1;
                if (ack_wait == 5'd1) ack_pending <= 1'b0;
            end
        end
    end

    // checks beside the logic
    sequence rssi_seen(logic [1:0] code);
        RSSI_VALID_I && channel_clear_rule_select == code;
    endsequence
    sequence slotted_arm;
        ack_arm && slotted_ack;
    endsequence

    hyst_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        rssi_seen(2'b01) and below_hyst |=> CHANNEL_CLEAR_O)
        else $error("clear not set below threshold minus hysteresis");
    reserved_rule_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        rssi_seen(2'b00) |=> !CHANNEL_CLEAR_O)
        else $error("reserved rule reported clear");
    thr_busy_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        rssi_seen(2'b11) and !below_thr |=> !CHANNEL_CLEAR_O)
        else $error("clear reported at or above threshold");
    coord_accept_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        RX_FRAME_END_I && coordinator_role && RX_NO_DEST_I |=> FRAME_ACCEPT_O)
        else $error("coordinator dropped frame without destination");
    decode_off_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        RX_FRAME_END_I && !addr_decode_enable |=> FRAME_ACCEPT_O && RX_DONE_O)
        else $error("frame refused with address decoding off");
    preamble_len_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        tx_state == TX_SYNC && $past(tx_state) == TX_PRE |-> $past(tx_cnt) == pre_last)
        else $error("preamble length differs from code");
    sync_byte_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        take && tx_state == TX_SYNC && !last_cnt |=> TX_BYTE_O == sync_lo && TX_BYTE_VALID_O)
        else $error("first sync byte wrong");
    crc_append_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        take && in_data && fifo_data[8] && auto_checksum_enable |=> tx_state == TX_CRC)
        else $error("checksum not appended after last byte");
    ack_normal_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        ack_arm && !slotted_ack |=> ack_pending && ack_wait == ACK_SYMBOLS && sym_div == 10'd0)
        else $error("normal acknowledgement delay not 12 symbols");
    ack_slot_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        slotted_arm |=> ack_wait >= ACK_SYMBOLS &&
            (($past(sfd_phase) + ack_wait) % SLOT_SYMBOLS) == 0)
        else $error("slotted acknowledgement not aligned to 20 symbols");
endmodule

`default_nettype wire

// [common/radio_modem_pkg.sv]
package radio_modem_pkg;
    // register map in the cpu's external data space
    localparam logic [15:0] FILTER_CTRL_ADDR   = 16'hdf02;
    localparam logic [15:0] FRAME_CTRL_ADDR    = 16'hdf03;
    localparam logic [15:0] ACK_CORR_CTRL_ADDR = 16'hdf04;
    localparam logic [15:0] CLEAR_THR_ADDR     = 16'hdf05;
    // reset values
    localparam logic [7:0]  FILTER_CTRL_RST    = 8'h0a;
    localparam logic [7:0]  FRAME_CTRL_RST     = 8'he2;
    localparam logic [7:0]  ACK_CORR_CTRL_RST  = 8'h30;
    localparam logic [7:0]  CLEAR_THR_RST      = 8'he0;
    // writable bits; reserved filter bits read back as zero
    localparam logic [7:0]  FILTER_CTRL_WMASK  = 8'h1f;
    // field positions
    localparam int COORD_BIT    = 4;
    localparam int ADDR_DEC_BIT = 3;
    localparam int HYST_MSB     = 2;
    localparam int RULE_MSB     = 7;
    localparam int RULE_LSB     = 6;
    localparam int CRC_EN_BIT   = 5;
    localparam int ACK_EN_BIT   = 4;
    localparam int PRE_MSB      = 3;
    localparam int SLOT_BIT     = 7;
    localparam int LEVEL_BIT    = 5;
    localparam int CORR_MSB     = 4;
    // clear-channel rule codes
    localparam logic [1:0] RULE_RESERVED = 2'b00;
    localparam logic [1:0] RULE_HYST     = 2'b01;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SYMBOL_NS     = 16000;
    localparam int SYMBOL_CYCLES = SYMBOL_NS / CLK_PERIOD_NS;
    localparam logic [4:0] ACK_SYMBOLS  = 5'd12;
    localparam logic [4:0] SLOT_SYMBOLS = 5'd20;
    // crc-16, x^16+x^12+x^5+1 reflected for lsb-first bit order
    localparam logic [15:0] CRC_POLY_REV = 16'h8408;
    localparam logic [15:0] CRC_INIT     = 16'h0000;
    localparam logic [15:0] SYNC_DEFAULT = 16'ha70f;
    // transmit byte buffer
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 16;
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_PRE  = 5'b00010,
        TX_SYNC = 5'b00100,
        TX_DATA = 5'b01000,
        TX_CRC  = 5'b10000
    } tx_state_e;
endpackage

// [verification/remote_radio_model.sv]
`timescale 1ns/1ps
`default_nettype none

// far radio: link sink that stalls now and then, and a symbol/byte source
module remote_radio_model (
    input  wire logic       clk_i,
    input  wire logic       stall_i,
    output logic            ready_o,
    output logic [3:0]      nib_o,
    output logic            nib_valid_o,
    output logic [7:0]      byte_o,
    output logic            byte_valid_o
);
    logic [2:0] cnt = 3'h0;

    // idle lines never repeat the last value, so stale data cannot pass
    initial begin
        ready_o = 1'b0;
        nib_o = 4'h5;
        nib_valid_o = 1'b0;
        byte_o = 8'h5a;
        byte_valid_o = 1'b0;
    end

    // one stall cycle in eight keeps the transmitter honest
    always @(negedge clk_i) begin
        cnt <= cnt + 3'h1;
        ready_o <= !stall_i && cnt != 3'h3;
    end

    task automatic send_nib(input logic [3:0] n);
        @(negedge clk_i);
        nib_o = n;
        nib_valid_o = 1'b1;
        @(negedge clk_i);
        nib_valid_o = 1'b0;
        nib_o = ~n;
    endtask

    task automatic send_byte(input logic [7:0] b);
        @(negedge clk_i);
        byte_o = b;
        byte_valid_o = 1'b1;
        @(negedge clk_i);
        byte_valid_o = 1'b0;
        byte_o = ~b;
    endtask
endmodule

`default_nettype wire

// [verification/tb_radio_modem_frame_control.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_radio_modem_frame_control;
    import radio_modem_pkg::*;
    logic        clk, rst_b, xwr, xrd, rssi_v, tx_v, tx_last, fend, nd, am, stall, rd_seen;
    logic [15:0] xaddr, crc;
    logic [7:0]  xwd, xrdo, rssi, tx_d, txb, rxb;
    logic [3:0]  rxn;
    logic [4:0]  corr;
    logic        areq;
    logic        cclr, tx_rdy, txb_v, txb_r, sync_f, rxb_v, rxn_v, acc, crc_ok, done, ack;
    logic [7:0]  rd_q[$], tx_q[$];
    logic [31:0] rs = 32'h725640e7;
    logic [31:0] r;
    int          error_cnt = 0, checked = 0, cyc = 0, n;

    radio_modem_frame_control i_dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .XADDR_I(xaddr),
        .XWDATA_I(xwd), .XWR_I(xwr), .XRD_I(xrd), .XRDATA_O(xrdo),
        .SYNC_PATTERN_I(16'ha70f), .RSSI_I(rssi), .RSSI_VALID_I(rssi_v),
        .CHANNEL_CLEAR_O(cclr), .TX_DATA_I(tx_d), .TX_LAST_I(tx_last), .TX_VALID_I(tx_v),
        .TX_READY_O(tx_rdy), .TX_BYTE_O(txb), .TX_BYTE_VALID_O(txb_v),
        .TX_BYTE_READY_I(txb_r), .RX_NIBBLE_I(rxn), .RX_NIBBLE_VALID_I(rxn_v),
        .CORR_LEVEL_I(corr), .RX_SYNC_FOUND_O(sync_f), .RX_BYTE_I(rxb),
        .RX_BYTE_VALID_I(rxb_v), .RX_FRAME_END_I(fend), .RX_NO_DEST_I(nd),
        .RX_ADDR_MATCH_I(am), .RX_ACK_REQ_I(areq), .FRAME_ACCEPT_O(acc),
        .RX_CRC_OK_O(crc_ok), .RX_DONE_O(done), .ACK_START_O(ack));

    remote_radio_model i_partner (.clk_i(clk), .stall_i(stall), .ready_o(txb_r),
        .nib_o(rxn), .nib_valid_o(rxn_v), .byte_o(rxb), .byte_valid_o(rxb_v));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // own lsb-first crc, kept apart from anything the design computes
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        c ^= {8'h00, b};
        for (int i = 0; i < 8; i++)
            c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        return c;
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        xaddr = a;
        xwd = d;
        xwr = 1'b1;
        @(negedge clk);
        xwr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        xaddr = a;
        xrd = 1'b1;
        rd_q.push_back(e);
        @(negedge clk);
        xrd = 1'b0;
    endtask

    // link held off while the buffer fills, then released to drain it
    task automatic tx_frame(input logic [3:0] code, input int len);
        wr(16'hdf03, {4'he, code});
        stall = 1'b1;
        crc = 16'h0000;
        for (int i = 0; i < 2 * code + 2; i++)
            tx_q.push_back(8'h00);
        tx_q.push_back(8'h00);
        tx_q.push_back(8'ha7);
        for (int i = 0; i < len; i++) begin
            r = xs();
            @(negedge clk);
            tx_d = r[7:0];
            tx_last = (i == len - 1);
            tx_v = 1'b1;
            tx_q.push_back(r[7:0]);
            crc = crc_upd(crc, r[7:0]);
        end
        @(negedge clk);
        tx_v = 1'b0;
        chk("buffer ready", tx_rdy, len < 16);
        tx_q.push_back(crc[7:0]);
        tx_q.push_back(crc[15:8]);
        stall = 1'b0;
        n = 0;
        while (tx_q.size() > 0 && n < 600) begin
            @(negedge clk);
            n++;
        end
        chk("bytes left", tx_q.size(), 0);
    endtask

    // sync sent lsb nibble first after an implicit zero, then bytes and fcs
    task automatic rx_frame(input logic nod, input logic match, input logic bad);
        for (int i = 0; i < 4; i++)
            i_partner.send_nib(i < 2 ? 4'h0 : (i == 2 ? 4'h7 : 4'ha));
        n = 0;
        while (sync_f !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chk("sync found", sync_f, 1'b1);
        crc = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            r = xs();
            i_partner.send_byte(r[7:0]);
            crc = crc_upd(crc, r[7:0]);
        end
        i_partner.send_byte(crc[7:0] ^ {7'h00, bad});
        i_partner.send_byte(crc[15:8]);
        @(negedge clk);
        nd = nod;
        am = match;
        fend = 1'b1;
        @(negedge clk);
        fend = 1'b0;
    endtask

    // read answers and link bytes are compared against the oldest note
    always @(posedge clk) rd_seen <= xrd;
    always @(negedge clk) if (rd_seen) chk("read data", xrdo, rd_q.pop_front());
    always @(posedge clk) if (txb_v && txb_r) chk("tx byte", txb, tx_q.pop_front());

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        {xwr, xrd, rssi_v, tx_v, tx_last, fend, nd, am, stall, rst_b} = '0;
        {areq, corr} = 6'h34;
        {xaddr, xwd, rssi, tx_d} = '0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        rd(16'hdf02, 8'h0a);
        rd(16'hdf03, 8'he2);
        rd(16'hdf04, 8'h30);
        rd(16'hdf05, 8'he0);
        wr(16'hdf02, 8'hff);
        rd(16'hdf02, 8'h1f);
        wr(16'hdf06, 8'h55);
        rd(16'hdf06, 8'h00);
        wr(16'hdf04, 8'h14);
        rd(16'hdf04, 8'h14);
        // correlation just under the threshold must not start a search
        corr = 5'h13;
        for (int i = 0; i < 4; i++)
            i_partner.send_nib(i < 2 ? 4'h0 : (i == 2 ? 4'h7 : 4'ha));
        chk("sync below level", sync_f, 1'b0);
        corr = 5'h14;
        wr(16'hdf02, 8'h0a);
        wr(16'hdf05, 8'hf0);
        // rssi around both thresholds, hysteresis 2 only in rule 01
        for (int m = 0; m < 4; m++) begin
            wr(16'hdf03, {m[1:0], 6'h22});
            for (int k = 0; k < 12; k++) begin
                r = xs();
                @(negedge clk);
                rssi = 8'hec + {5'h00, r[2:0]};
                rssi_v = 1'b1;
                @(negedge clk);
                rssi_v = 1'b0;
                chk("clear", cclr, m != 0 && $signed(rssi) < (m == 1 ? -18 : -16));
            end
        end
        tx_frame(4'h0, 16);
        tx_frame(4'hf, 1);
        // filter table: decode on/off, coordinator, bad fcs
        wr(16'hdf03, 8'he2);
        for (int k = 0; k < 6; k++) begin
            wr(16'hdf02, k == 2 ? 8'h02 : (k == 3 ? 8'h1a : 8'h0a));
            rx_frame(6'b011000 >> k, 6'b100001 >> k, k == 5);
            chk("accept", acc, (6'b101101 >> k) & 6'h01);
            chk("crc ok", crc_ok, k != 5);
            chk("done", done, 1'b1);
        end
        wr(16'hdf03, 8'hf2);
        rx_frame(1'b0, 1'b1, 1'b0);
        n = 0;
        while (ack !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        chk("ack delay", n, 12 * SYMBOL_CYCLES);
        // no request with good fcs, then request with bad fcs: both silent
        for (int k = 0; k < 2; k++) begin
            areq = k[0];
            rx_frame(1'b0, 1'b1, k[0]);
            n = 0;
            repeat (7800) begin
                @(negedge clk);
                n += ack;
            end
            chk("ack refused", n, 0);
        end
        // slotted, extended filtering; frame far shorter than a symbol
        wr(16'hdf04, 8'hb4);
        rx_frame(1'b0, 1'b1, 1'b0);
        n = 0;
        while (ack !== 1'b1 && n < 14000) begin
            @(negedge clk);
            n++;
        end
        chk("slotted ack delay", n, 20 * SYMBOL_CYCLES);
        results();
    end
endmodule

`default_nettype wire
